// ### src/lcds_map.vh
`ifndef LCDS_MAP_VH
`define LCDS_MAP_VH
// register byte offsets
`define LCDS_OFS_SUPPLY 8'h00
`define LCDS_OFS_CTL0 8'h04
`define LCDS_OFS_CTL1 8'h08
`define LCDS_OFS_BLINK 8'h0c
`define LCDS_OFS_PEN0 8'h10
`define LCDS_OFS_BPEN0 8'h20
`define LCDS_OFS_STATUS 8'h30
`define LCDS_OFS_WF0 8'h80
// supply control fields
`define LCDS_SUP_PUMP_ON 7
`define LCDS_SUP_ADJ_HI 5
`define LCDS_SUP_ADJ_LO 4
`define LCDS_SUP_SEL_HI 1
`define LCDS_SUP_SEL_LO 0
`define LCDS_SUPPLY_TOP 2'h3
// control zero fields
`define LCDS_C0_ENABLE 7
`define LCDS_C0_SOURCE 6
`define LCDS_C0_DIV_HI 5
`define LCDS_C0_DIV_LO 3
`define LCDS_C0_DUTY_HI 2
`define LCDS_C0_DUTY_LO 0
`define LCDS_DUTY_EIGHTH 3'h7
// control one fields
`define LCDS_C1_IRQ_EN 7
`define LCDS_C1_WAIT_RUN 1
`define LCDS_C1_STOP_RUN 0
// blink control fields
`define LCDS_BL_ON 7
`define LCDS_BL_PLANE2 6
`define LCDS_BL_BLANK 5
`define LCDS_BL_STYLE 3
`define LCDS_BL_RATE_HI 2
`define LCDS_BL_RATE_LO 0
// reset values
`define LCDS_RST_BYTE 8'h00
// timing: crystal rate, display clocks per phase per divider step, blink shift
`define LCDS_XTAL_HZ 32768
`define LCDS_PHASE_BASE 16'h0017
`define LCDS_BLINK_SHIFT 5'h0b
`endif

// ### src/lcds_top.v
`timescale 1ns/1ps
`default_nettype none
`include "lcds_map.vh"
module lcds_top #(
    parameter [15:0] PHASE_BASE = `LCDS_PHASE_BASE,
    parameter [4:0] BLINK_SHIFT = `LCDS_BLINK_SHIFT
) (
    input wire clk,
    input wire sys_rst,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire wait_mode,
    input wire stop_mode,
    input wire crystal_oscillator_output,
    input wire alt_clock_ref,
    output reg charge_pump_on,
    output reg [1:0] pump_clock_adjust,
    output reg use_top_level_display_supply,
    output reg [31:0] seg_level,
    output reg [31:0] seg_oe,
    output reg [31:0] seg_is_backplane,
    output reg frame_irq
);
    localparam ST_IDLE = 2'b00;
    localparam ST_SCAN = 2'b01;
    localparam ST_COMMIT = 2'b10;

    reg [7:0] display_supply_control;
    reg [7:0] display_control_zero;
    reg [7:0] display_control_one;
    reg [7:0] blink_control;
    reg [7:0] pin_enable [0:3];
    reg [7:0] backplane_enable [0:3];
    reg frame_flag;

    wire [31:0] pin_enable_all;
    wire [31:0] backplane_all;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_flat
            assign pin_enable_all[8*g+:8] = pin_enable[g];
            assign backplane_all[8*g+:8] = backplane_enable[g];
        end
    endgenerate

    // register decode, used by both read and write paths
    function [3:0] reg_sel;
        input [7:0] a;
        begin
            if (a[7]) begin
                reg_sel = 4'hf;
            end else begin
                case (a)
                    `LCDS_OFS_SUPPLY: reg_sel = 4'h1;
                    `LCDS_OFS_CTL0: reg_sel = 4'h2;
                    `LCDS_OFS_CTL1: reg_sel = 4'h3;
                    `LCDS_OFS_BLINK: reg_sel = 4'h4;
                    `LCDS_OFS_STATUS: reg_sel = 4'h5;
                    default: begin
                        if (a[7:4] == 4'h1 && a[1:0] == 2'h0) begin
                            reg_sel = 4'h6;
                        end else if (a[7:4] == 4'h2 && a[1:0] == 2'h0) begin
                            reg_sel = 4'h7;
                        end else begin
                            reg_sel = 4'h0;
                        end
                    end
                endcase
            end
        end
    endfunction

    wire [3:0] sel = reg_sel(paddr);
    wire wf_hit = paddr[7] && (paddr[1:0] == 2'h0);
    wire wr_fire = psel && penable && pready && pwrite;
    wire [7:0] wf_bus_data;
    wire [7:0] wf_scan_data;
    reg [5:0] scan_idx;

    lcds_wf_mem #(
        .WIDTH(8),
        .DEPTH(32),
        .AW(5)
    ) u_wf (
        .clk(clk),
        .clk_en(clk_en),
        .wr_en(wr_fire && wf_hit),
        .wr_addr(paddr[6:2]),
        .wr_data(pwdata[7:0]),
        .rd_addr_a(paddr[6:2]),
        .rd_data_a(wf_bus_data),
        .rd_addr_b(scan_idx[4:0]),
        .rd_data_b(wf_scan_data)
    );

    // one wait state: the memory word read at setup is ready for the access edge
    always @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clk_en) begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                // an unaligned waveform offset is a hole like any other: refused, read 0, write dropped
                pslverr <= (sel == 4'h0) || (sel == 4'hf && !wf_hit);
                case (sel)
                    4'h1: prdata <= {24'h0, display_supply_control};
                    4'h2: prdata <= {24'h0, display_control_zero};
                    4'h3: prdata <= {24'h0, display_control_one};
                    4'h4: prdata <= {24'h0, blink_control};
                    4'h5: prdata <= {31'h0, frame_flag};
                    4'h6: prdata <= {24'h0, pin_enable[paddr[3:2]]};
                    4'h7: prdata <= {24'h0, backplane_enable[paddr[3:2]]};
                    4'hf: prdata <= wf_hit ? {24'h0, wf_bus_data} : 32'h0;
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    integer i;
    always @(posedge clk) begin
        if (sys_rst) begin
            display_supply_control <= `LCDS_RST_BYTE;
            display_control_zero <= `LCDS_RST_BYTE;
            display_control_one <= `LCDS_RST_BYTE;
            blink_control <= `LCDS_RST_BYTE;
            for (i = 0; i < 4; i = i + 1) begin
                pin_enable[i] <= `LCDS_RST_BYTE;
                backplane_enable[i] <= `LCDS_RST_BYTE;
            end
        end else if (clk_en && wr_fire) begin
            // all fields stay writable while running; software orders enable last
            case (sel)
                4'h1: display_supply_control <= pwdata[7:0];
                4'h2: display_control_zero <= pwdata[7:0];
                4'h3: display_control_one <= pwdata[7:0];
                4'h4: blink_control <= pwdata[7:0];
                4'h6: pin_enable[paddr[3:2]] <= pwdata[7:0];
                4'h7: backplane_enable[paddr[3:2]] <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // supply and pump selections go straight out to the analog side
    always @(posedge clk) begin
        if (sys_rst) begin
            charge_pump_on <= 1'b0;
            pump_clock_adjust <= 2'h0;
            use_top_level_display_supply <= 1'b0;
        end else if (clk_en) begin
            charge_pump_on <= display_supply_control[`LCDS_SUP_PUMP_ON];
            pump_clock_adjust <= display_supply_control[`LCDS_SUP_ADJ_HI:`LCDS_SUP_ADJ_LO];
            use_top_level_display_supply <=
                (display_supply_control[`LCDS_SUP_SEL_HI:`LCDS_SUP_SEL_LO] == `LCDS_SUPPLY_TOP);
        end
    end

    // both clock sources are foreign: two flops, then a third for the edge
    reg [2:0] xtal_sync;
    reg [2:0] alt_sync;
    always @(posedge clk) begin
        if (sys_rst) begin
            xtal_sync <= 3'h0;
            alt_sync <= 3'h0;
        end else if (clk_en) begin
            xtal_sync <= {xtal_sync[1:0], crystal_oscillator_output};
            alt_sync <= {alt_sync[1:0], alt_clock_ref};
        end
    end
    wire xtal_rise = xtal_sync[1] && !xtal_sync[2];
    wire alt_rise = alt_sync[1] && !alt_sync[2];
    wire disp_tick = display_control_zero[`LCDS_C0_SOURCE] ? alt_rise : xtal_rise;

    wire [2:0] divider = display_control_zero[`LCDS_C0_DIV_HI:`LCDS_C0_DIV_LO];
    wire [2:0] duty = display_control_zero[`LCDS_C0_DUTY_HI:`LCDS_C0_DUTY_LO];
    wire [15:0] phase_len = PHASE_BASE * {13'h0, divider} + PHASE_BASE;
    wire running = display_control_zero[`LCDS_C0_ENABLE]
        && !(wait_mode && !display_control_one[`LCDS_C1_WAIT_RUN])
        && !(stop_mode && !display_control_one[`LCDS_C1_STOP_RUN]);

    reg was_running;
    reg [15:0] phase_timer;
    reg [2:0] phase;
    reg [1:0] state;
    wire phase_end = disp_tick && (phase_timer == phase_len - 16'h1);
    wire [2:0] next_phase = (phase == duty) ? 3'h0 : phase + 3'h1;
    wire start = running && !was_running;

    // blink half-period is 2^(rate+shift) display clocks; rate 010 gives 2 Hz
    reg [18:0] blink_cnt;
    reg blink_off_half;
    wire blink_on = blink_control[`LCDS_BL_ON];
    wire [4:0] blink_exp = {2'h0, blink_control[`LCDS_BL_RATE_HI:`LCDS_BL_RATE_LO]} + BLINK_SHIFT;
    wire [18:0] blink_half = 19'h1 << blink_exp;
    always @(posedge clk) begin
        if (sys_rst) begin
            blink_cnt <= 19'h0;
            blink_off_half <= 1'b0;
        end else if (clk_en) begin
            if (!blink_on || !running) begin
                blink_cnt <= 19'h0;
                blink_off_half <= 1'b0;
            end else if (disp_tick) begin
                if (blink_cnt >= blink_half - 19'h1) begin
                    blink_cnt <= 19'h0;
                    blink_off_half <= !blink_off_half;
                end else begin
                    blink_cnt <= blink_cnt + 19'h1;
                end
            end
        end
    end

    wire blink_style_alt = blink_control[`LCDS_BL_STYLE];
    wire blank_now = blink_control[`LCDS_BL_BLANK]
        || (blink_off_half && !blink_style_alt);
    // the second plane lives in the upper nibble, so it only exists up to four phases
    wire plane_two = (blink_control[`LCDS_BL_PLANE2] ^ (blink_off_half && blink_style_alt))
        && (duty < 3'h4);
    wire [2:0] bit_sel = plane_two ? phase + 3'h4 : phase;
    wire scan_bit = wf_scan_data[bit_sel];

    reg [31:0] pending;
    reg [31:0] image;
    always @* begin
        image = pending;
        image[31] = scan_bit;
    end

    // phase sequencer: each phase start rescans all 32 waveform bytes
    always @(posedge clk) begin
        if (sys_rst) begin
            was_running <= 1'b0;
            phase_timer <= 16'h0;
            phase <= 3'h0;
            state <= ST_IDLE;
            scan_idx <= 6'h0;
            pending <= 32'h0;
            seg_level <= 32'h0;
            seg_oe <= 32'h0;
            seg_is_backplane <= 32'h0;
        end else if (clk_en) begin
            was_running <= running;
            if (!running) begin
                phase_timer <= 16'h0;
                phase <= 3'h0;
                state <= ST_IDLE;
                scan_idx <= 6'h0;
                seg_level <= 32'h0;
                seg_oe <= 32'h0;
            end else begin
                if (start) begin
                    phase_timer <= 16'h0;
                    phase <= 3'h0;
                end else if (phase_end) begin
                    phase_timer <= 16'h0;
                    phase <= next_phase;
                end else if (disp_tick) begin
                    phase_timer <= phase_timer + 16'h1;
                end
                case (state)
                    ST_IDLE: begin
                        if (start || phase_end) begin
                            state <= ST_SCAN;
                            scan_idx <= 6'h0;
                        end
                    end
                    ST_SCAN: begin
                        if (scan_idx != 6'h0) begin
                            pending[scan_idx[4:0] - 5'h1] <= scan_bit;
                        end
                        if (scan_idx == 6'h1f) begin
                            state <= ST_COMMIT;
                        end else begin
                            scan_idx <= scan_idx + 6'h1;
                        end
                    end
                    ST_COMMIT: begin
                        // blanking hits frontplanes only so backplanes keep cycling
                        seg_level <= image & (backplane_all | {32{!blank_now}}) & pin_enable_all;
                        seg_oe <= pin_enable_all;
                        seg_is_backplane <= backplane_all & pin_enable_all;
                        state <= ST_IDLE;
                        scan_idx <= 6'h0;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // frame flag: set on each phase-zero start, write one to clear, set wins
    wire frame_start = running && (start || (phase_end && next_phase == 3'h0));
    wire flag_clr = wr_fire && (sel == 4'h5) && pwdata[0];
    always @(posedge clk) begin
        if (sys_rst) begin
            frame_flag <= 1'b0;
            frame_irq <= 1'b0;
        end else if (clk_en) begin
            if (frame_start) begin
                frame_flag <= 1'b1;
            end else if (flag_clr) begin
                frame_flag <= 1'b0;
            end
            frame_irq <= (frame_flag || frame_start) && !(flag_clr && !frame_start)
                && display_control_one[`LCDS_C1_IRQ_EN];
        end
    end
endmodule // lcds_top
`default_nettype wire

// ### src/lcds_wf_mem.v
`timescale 1ns/1ps
`default_nettype none
module lcds_wf_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire clk_en,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr_a,
    output reg [WIDTH-1:0] rd_data_a,
    input wire [AW-1:0] rd_addr_b,
    output reg [WIDTH-1:0] rd_data_b
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // no reset on the array: contents are undefined until software writes them
    always @(posedge clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data_a <= mem[rd_addr_a];
            rd_data_b <= mem[rd_addr_b];
        end
    end
endmodule // lcds_wf_mem
`default_nettype wire

// ### verification/lcds_glass.sv
`timescale 1ns/1ps
`default_nettype none
module lcds_glass (
    input wire [31:0] seg_level,
    input wire [31:0] seg_oe,
    input wire [31:0] seg_is_backplane,
    output wire [31:0] bp_act,
    output wire [31:0] fp_act
);
    // an undriven electrode floats on the glass, so it never reads as active
    assign bp_act = seg_level & seg_oe & seg_is_backplane;
    assign fp_act = seg_level & seg_oe & ~seg_is_backplane;
endmodule // lcds_glass
`default_nettype wire

// ### verification/lcds_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcds_top_chk #(
    parameter [15:0] PHASE_BASE = 16'h0001,
    parameter [4:0] BLINK_SHIFT = 5'h01
) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire wait_mode,
    input wire stop_mode,
    input wire charge_pump_on,
    input wire [1:0] pump_clock_adjust,
    input wire use_top_level_display_supply,
    input wire [31:0] seg_oe,
    input wire frame_irq
);
    // shadow of control one, kept from completed writes
    logic irq_en;
    logic wait_run;
    logic stop_run;
    always @(posedge clk) begin
        if (sys_rst) begin
            irq_en <= 1'b0;
            wait_run <= 1'b0;
            stop_run <= 1'b0;
        end else if (pready && pwrite && paddr == 8'h08) begin
            irq_en <= pwdata[7];
            wait_run <= pwdata[1];
            stop_run <= pwdata[0];
        end
    end
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[7] || a <= 8'h30) && a[1:0] == 2'h0;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_supply;
        logic [7:0] v;
        (pready && pwrite && paddr == 8'h00, v = pwdata[7:0]) |-> ##2 use_top_level_display_supply == (v[1:0] == 2'h3);
    endproperty
    property p_pump;
        logic [7:0] v;
        (pready && pwrite && paddr == 8'h00, v = pwdata[7:0]) |-> ##2 pump_clock_adjust == v[5:4] && charge_pump_on == v[7];
    endproperty
    a_pready_wait: assert property (s_setup ##1 s_access |=> pready)
        else $error("pready late");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped(paddr))
        else $error("pslverr wrong");
    a_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_supply_sel: assert property (p_supply)
        else $error("supply select not applied");
    a_pump_adjust: assert property (p_pump)
        else $error("pump fields not applied");
    a_irq_gate: assert property (!irq_en && !$past(irq_en) |-> !frame_irq)
        else $error("irq while masked");
    a_wait_off: assert property ((wait_mode && !wait_run) [*3] |-> seg_oe == 32'h0)
        else $error("driving in wait");
    a_stop_off: assert property ((stop_mode && !stop_run) [*3] |-> seg_oe == 32'h0)
        else $error("driving in stop");
    a_irq_clear: assert property (pready && pwrite && paddr == 8'h30 && pwdata[0] |-> ##[1:3] !frame_irq)
        else $error("irq not cleared");
endmodule // lcds_top_chk
`default_nettype wire

// ### verification/lcds_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module lcds_top_test;
    localparam logic [31:0] PEN = 32'h1fffffff;
    localparam int PB = 1;
    logic clk, sys_rst, psel, penable, pwrite, wait_mode, stop_mode;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd, bpm, v;
    logic [2:0] xc = 3'h0;
    logic [2:0] p;
    logic [7:0] wf [32];
    logic [2:0] ph [32];
    logic [7:0] seen;
    logic er;
    int n_mismatch, compares, n, i, k, r, b, base, off;
    wire [31:0] prdata, seg_level, seg_oe, seg_is_backplane, bp_act, fp_act;
    wire pready, pslverr, charge_pump_on, use_top_level_display_supply, frame_irq;
    wire [1:0] pump_clock_adjust;
    lcds_top #(.PHASE_BASE(16'h0001), .BLINK_SHIFT(5'h01)) i_lcds_top (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .crystal_oscillator_output(xc[2]), .alt_clock_ref(1'b0),
        .charge_pump_on(charge_pump_on), .pump_clock_adjust(pump_clock_adjust),
        .use_top_level_display_supply(use_top_level_display_supply), .seg_level(seg_level),
        .seg_oe(seg_oe), .seg_is_backplane(seg_is_backplane), .frame_irq(frame_irq));
    lcds_glass i_lcds_glass (.seg_level(seg_level), .seg_oe(seg_oe), .seg_is_backplane(seg_is_backplane),
        .bp_act(bp_act), .fp_act(fp_act));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // crystal stand-in: 8 clk period, slow enough for the design's synchroniser
    always @(posedge clk) xc <= xc + 3'h1;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task apb(input logic w, input int a, input logic [31:0] d);
        int t;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= 8'(a);
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        // values read right after the edge are the ones the edge sampled
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (t >= 40) chk("pready", 1, 0);
    endtask
    task wait_chg;
        logic [31:0] l;
        l = bp_act;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bp_act === l && n < 300);
    endtask
    function automatic logic [31:0] expfp(input logic [2:0] q);
        for (int j = 0; j < 32; j++) expfp[j] = wf[j][q] & PEN[j] & ~bpm[j];
    endfunction
    function automatic logic [2:0] pof(input logic [31:0] a);
        pof = 3'h0;
        for (int j = 0; j < 32; j++) if (a[j]) pof = ph[j];
    endfunction
    task end_sim;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim;
    end
    initial begin
        {sys_rst, psel, penable, pwrite, wait_mode, stop_mode, paddr, pwdata} = {1'b1, 45'h0};
        n = $urandom(80275);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk("oe reset", 0, seg_oe);
        for (i = 0; i < 12; i++) begin
            v = $urandom & 32'hff;
            if (i == 1) v[7] = 1'b0;
            apb(0, i * 4, 0);
            chk("reset value", 0, rd);
            apb(1, i * 4, v);
            apb(0, i * 4, 0);
            chk("readback", v, rd);
        end
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            v = ($urandom & 32'hfc) | i;
            apb(1, 0, v);
            repeat (3) @(posedge clk);
            chk("top supply", i == 3, use_top_level_display_supply);
            chk("pump adjust", v[5:4], pump_clock_adjust);
            chk("pump on", v[7], charge_pump_on);
        end
        apb(0, 8'h40, 0);
        chk("unmapped read", 1, er);
        apb(1, 8'h34, 32'h55);
        chk("unmapped write", 1, er);
        $display("test supply done");
        for (r = 0; r < 2; r++) begin
            base = r ? $urandom % 22 : 0;
            off = r ? $urandom % 8 : 0;
            bpm = 32'hff << base;
            apb(1, 8'h04, 32'h2f);
            apb(1, 8'h08, 0);
            apb(1, 8'h0c, 32'h02);
            for (i = 0; i < 4; i++) begin
                apb(1, 8'h10 + i * 4, PEN >> (i * 8) & 32'hff);
                apb(1, 8'h20 + i * 4, bpm >> (i * 8) & 32'hff);
            end
            for (i = 0; i < 32; i++) begin
                ph[i] = 3'(i - base + off);
                wf[i] = bpm[i] ? 8'h01 << ph[i] : 8'($urandom);
                apb(1, 8'h80 + i * 4, wf[i]);
            end
            apb(1, 8'h04, 32'haf);
            repeat (120) @(posedge clk);
            chk("pins driven", PEN, seg_oe);
            chk("backplanes", bpm, seg_is_backplane);
            seen = 8'h0;
            for (k = 0; k < 24; k++) begin
                repeat (17) @(negedge clk);
                chk("one backplane", 1, $onehot(bp_act));
                p = pof(bp_act);
                seen[p] = 1'b1;
                chk("frontplanes", expfp(p), fp_act);
            end
            chk("phases", 8'hff, seen);
            wait_chg;
            wait_chg;
            chk("phase period", PB * 6 * 8, n);
            $display("test placement %0d done", r);
        end
        @(posedge clk);
        wait_mode <= 1'b1;
        repeat (5) @(posedge clk);
        chk("wait off", 0, seg_oe);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (5) @(posedge clk);
        chk("stop off", 0, seg_oe);
        stop_mode <= 1'b0;
        apb(1, 8'h08, 32'h03);
        wait_mode <= 1'b1;
        stop_mode <= 1'b1;
        repeat (100) @(posedge clk);
        chk("modes run", PEN, seg_oe);
        wait_mode <= 1'b0;
        stop_mode <= 1'b0;
        $display("test power modes done");
        apb(1, 8'h08, 0);
        repeat (400) @(posedge clk);
        chk("irq masked", 0, frame_irq);
        apb(0, 8'h30, 0);
        chk("frame flag", 1, rd[0]);
        apb(1, 8'h08, 32'h80);
        repeat (3) @(posedge clk);
        chk("irq raised", 1, frame_irq);
        apb(1, 8'h30, 1);
        repeat (2) @(posedge clk);
        chk("irq cleared", 0, frame_irq);
        for (k = 0; k < 500 && frame_irq !== 1'b1; k++) @(posedge clk);
        chk("irq next frame", 1, frame_irq);
        apb(1, 8'h08, 0);
        $display("test frame irq done");
        apb(1, 8'h0c, 32'h22);
        repeat (100) @(negedge clk);
        chk("blank fp", 0, fp_act);
        chk("blank bp", 1, |bp_act);
        apb(1, 8'h0c, 32'h82);
        b = 0;
        for (k = 0; k < 40; k++) begin
            repeat (5) @(negedge clk);
            if (fp_act === 32'h0) b++;
        end
        chk("blink dark", 1, b > 0 && b < 40);
        apb(1, 8'h0c, 32'h02);
        repeat (100) @(negedge clk);
        chk("blink off", expfp(pof(bp_act)), fp_act);
        $display("test blink done");
        end_sim;
    end
endmodule // lcds_top_test
bind lcds_top lcds_top_chk #(.PHASE_BASE(PHASE_BASE), .BLINK_SHIFT(BLINK_SHIFT)) i_lcds_top_chk (
    .clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .wait_mode,
    .stop_mode, .charge_pump_on, .pump_clock_adjust, .use_top_level_display_supply, .seg_oe, .frame_irq);
`default_nettype wire
